// [rsc_defines.vh]
// rsc_defines.vh: offsets, field positions, resets and counts of the
// radio sequencer config block. assumes inclusion by bare name.
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH
`define RSC_ADDR_W          6
`define RSC_CFG_IDX         6'h17
`define RSC_CFG_ADDR        8'h5C
`define RSC_STAT_ADDR       8'h60
`define RSC_CTRL_ADDR       8'h64
`define RSC_CAL_LSB         4
`define RSC_CAL_MSB         5
`define RSC_PO_LSB          2
`define RSC_PO_MSB          3
`define RSC_SPARE_BIT       1
`define RSC_KEEP_BIT        0
`define RSC_CFG_RESET       8'h04
`define RSC_CAL_NEVER       2'h0
`define RSC_CAL_FROM_IDLE   2'h1
`define RSC_CAL_TO_IDLE     2'h2
`define RSC_CAL_EVERY4      2'h3
`define RSC_EXP_0           9'h001
`define RSC_EXP_1           9'h010
`define RSC_EXP_2           9'h040
`define RSC_EXP_3           9'h100
`define RSC_RIPPLE_MAX      6'h3F
`endif

// [rsc_top.v]
// rsc_top.v: sequencer config register, auto-calibration decision and
// power-on ready delay. assumes an avalon-mm master on mclk and a state
// machine that reports its transitions as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.vh"
// Operation
// - select 0: calibrate only on the manual calibrate strobe or a ctrl write of bit 0 at 8'h64
// - select 1: calibrate on every idle to rx, tx or synth-on transition
// - select 2: calibrate each automatic return idle; 3: every fourth
// - chip ready stays high until ripple counter expired selected times
// - delay select 0,1,2,3 gives 1,16,64,256 expiries of the counter
// - osc stable asserts together with chip ready, no gap between them
module rsc_top (
   input  wire        mclk,
   input  wire        reset,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg         avs_response_err,
   input  wire        calibrate_strobe,
   input  wire        idle_to_active,
   input  wire        auto_to_idle,
   input  wire        osc_settled,
   input  wire        in_sleep,
   output reg         synth_cal_start,
   output reg         osc_run,
   output reg         chip_ready_n,
   output reg         osc_stable
);
   localparam ST_WAIT  = 3'b001;
   localparam ST_COUNT = 3'b010;
   localparam ST_READY = 3'b100;

   reg  [7:0] cfg_q;
   reg  [7:0] cfg_d;
   reg  [1:0] ret_cnt_q;
   reg  [1:0] ret_cnt_d;
   reg        cal_d;
   reg  [2:0] st_q;
   reg  [2:0] st_d;
   reg  [5:0] rip_q;
   reg  [5:0] rip_d;
   reg  [8:0] exp_q;
   reg  [8:0] exp_d;
   reg        acc_q;
   reg  [31:0] rd_d;
   reg        err_d;
   wire       hit_cfg;
   wire       hit_stat;
   wire       hit_ctrl;
   wire [1:0] cal_sel;
   wire       take_w;


   function [8:0] rsc_expiries;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    rsc_expiries = `RSC_EXP_0;
            2'h1:    rsc_expiries = `RSC_EXP_1;
            2'h2:    rsc_expiries = `RSC_EXP_2;
            default: rsc_expiries = `RSC_EXP_3;
         endcase
      end
   endfunction

   // address decode shared by the three register slots
   function rsc_hit;
      input [7:0] addr;
      input [7:0] slot;
      begin
         rsc_hit = (addr == slot);
      end
   endfunction

   // select 3 pace: the fourth return of each group calibrates
   function rsc_fourth_return;
      input [1:0] cnt;
      begin
         rsc_fourth_return = (cnt == 2'h3);
      end
   endfunction

   // bits 7:6 forced low so reads of 7:6 stay zero; spare bit 1 stays writable
   function [7:0] rsc_cfg_merge;
      input [7:0]  old;
      input [31:0] wdata;
      input        lane;
      begin
         if (lane)
            rsc_cfg_merge = {2'b00, wdata[5:0]};
         else
            rsc_cfg_merge = old;
      end
   endfunction

   // status word: ready flags and the select 3 return count
   function [31:0] rsc_status_word;
      input       rdy_n;
      input       stable;
      input [1:0] cnt;
      begin
         rsc_status_word      = 32'h0000_0000;
         rsc_status_word[0]   = rdy_n;
         rsc_status_word[1]   = stable;
         rsc_status_word[3:2] = cnt;
      end
   endfunction

   // ready once the expiry count reaches the selected target
   function rsc_target_hit;
      input [8:0] cnt;
      input [1:0] sel;
      begin
         rsc_target_hit = (cnt == rsc_expiries(sel));
      end
   endfunction

   // oscillator stops only in sleep without the keep bit
   function rsc_osc_on;
      input sleeping;
      input keep;
      begin
         rsc_osc_on = !sleeping || keep;
      end
   endfunction

   assign hit_cfg  = rsc_hit(avs_address, `RSC_CFG_ADDR);
   assign hit_stat = rsc_hit(avs_address, `RSC_STAT_ADDR);
   assign hit_ctrl = rsc_hit(avs_address, `RSC_CTRL_ADDR);
   assign cal_sel  = cfg_q[`RSC_CAL_MSB:`RSC_CAL_LSB];
   // an access is taken only when none is in flight
   assign take_w   = (avs_read || avs_write) && !acc_q;


   // one wait cycle per access: accepted on the second edge
   always @* begin
      cfg_d = cfg_q;
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      if ((avs_read || avs_write) && !acc_q) begin
         if (hit_cfg) begin
            rd_d[7:0] = cfg_q;
            cfg_d = rsc_cfg_merge(cfg_q, avs_writedata,
                                  avs_write && avs_byteenable[0]);
         end else if (hit_stat) begin
            rd_d = rsc_status_word(chip_ready_n, osc_stable, ret_cnt_q);
         end else if (!hit_ctrl) begin
            err_d = 1'b1;
         end
      end
   end

   // idle exits calibrate under select 1
   // returns calibrate under 2, every fourth under 3
   always @* begin
      ret_cnt_d = ret_cnt_q;
      cal_d = calibrate_strobe;
      if ((avs_write && !acc_q && hit_ctrl && avs_byteenable[0]
          && avs_writedata[0]))
         cal_d = 1'b1;
      if (idle_to_active && cal_sel == `RSC_CAL_FROM_IDLE)
         cal_d = 1'b1;
      if (auto_to_idle && cal_sel == `RSC_CAL_TO_IDLE)
         cal_d = 1'b1;
      if (auto_to_idle && cal_sel == `RSC_CAL_EVERY4) begin
         ret_cnt_d = ret_cnt_q + 2'h1;
         if (rsc_fourth_return(ret_cnt_q))
            cal_d = 1'b1;
      end
   end

   always @* begin
      st_d  = st_q;
      rip_d = rip_q;
      exp_d = exp_q;
      case (st_q)
         ST_WAIT: begin
            rip_d = 6'h00;
            exp_d = 9'h000;
            if (osc_settled)
               st_d = ST_COUNT;
         end
         ST_COUNT: begin
            rip_d = rip_q + 6'h01;
            if (rip_q == `RSC_RIPPLE_MAX) begin
               exp_d = exp_q + 9'h001;
               if (rsc_target_hit(exp_q + 9'h001,
                                  cfg_q[`RSC_PO_MSB:`RSC_PO_LSB]))
                  st_d = ST_READY;
            end
            if (!osc_settled)
               st_d = ST_WAIT;
         end
         ST_READY: begin
            if (!osc_settled)
               st_d = ST_WAIT;
         end
         default: st_d = ST_WAIT;
      endcase
   end

   // bus side: config word and the answer registers
   always @(posedge mclk) begin
      if (reset) begin
         cfg_q            <= `RSC_CFG_RESET;
         acc_q            <= 1'b0;
         avs_readdata     <= 32'h0000_0000;
         avs_waitrequest  <= 1'b1;
         avs_response_err <= 1'b0;
      end else begin
         cfg_q           <= cfg_d;
         acc_q           <= take_w;
         avs_waitrequest <= !take_w;
         if (take_w) begin
            avs_readdata     <= rd_d;
            avs_response_err <= err_d;
         end
      end
   end

   // calibration pulse and the select 3 return counter
   always @(posedge mclk) begin
      if (reset) begin
         ret_cnt_q       <= 2'h0;
         synth_cal_start <= 1'b0;
      end else begin
         ret_cnt_q       <= ret_cnt_d;
         synth_cal_start <= cal_d;
      end
   end

   // ready delay counters; flags follow the next state, no lag between
   always @(posedge mclk) begin
      if (reset) begin
         st_q         <= ST_WAIT;
         rip_q        <= 6'h00;
         exp_q        <= 9'h000;
         chip_ready_n <= 1'b1;
         osc_stable   <= 1'b0;
      end else begin
         st_q         <= st_d;
         rip_q        <= rip_d;
         exp_q        <= exp_d;
         chip_ready_n <= (st_d != ST_READY);
         osc_stable   <= (st_d == ST_READY);
      end
   end

   // oscillator run request, one cycle behind sleep and keep bit
   always @(posedge mclk) begin
      if (reset) begin
         osc_run <= 1'b1;
      end else begin
         osc_run <= rsc_osc_on(in_sleep, cfg_q[`RSC_KEEP_BIT]);
      end
   end
endmodule
`default_nettype wire

// [rsc_monitor.sv]
// rsc_monitor.sv: port assertions for rsc_top.
// assumes cfg writes at 8'h5C are taken while waitrequest is high.
`timescale 1ns/10ps
`default_nettype none
module rsc_monitor (
   input wire logic        mclk, reset, avs_write, avs_waitrequest,
   input wire logic [7:0]  avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic        calibrate_strobe, idle_to_active, auto_to_idle,
   input wire logic        osc_settled, in_sleep, synth_cal_start, osc_run,
   input wire logic        chip_ready_n, osc_stable
);
   // shadow of cfg, updated on the same edge as the design's copy
   logic [7:0] cfg_q;
   wire        wr_cfg = avs_write && avs_waitrequest && avs_address == 8'h5C;
   always @(posedge mclk)
      if (reset) cfg_q <= 8'h04;
      else if (wr_cfg) cfg_q <= avs_writedata[7:0];
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_manual_cal: assert property (calibrate_strobe |=> synth_cal_start)
      else $error("no manual cal");
   a_never_cal: assert property (cfg_q[5:4] == 0 && !calibrate_strobe
      && !avs_write |=> !synth_cal_start) else $error("stray cal");
   a_start_cal: assert property (cfg_q[5:4] == 1 && idle_to_active
      |=> synth_cal_start) else $error("no start cal");
   a_return_cal: assert property (cfg_q[5:4] == 2 && auto_to_idle
      |=> synth_cal_start) else $error("no return cal");
   a_ready_hold: assert property (!osc_settled |-> ##[0:2] chip_ready_n)
      else $error("ready while unsettled");
   a_short_delay: assert property ($rose(osc_settled) && cfg_q[3:2] == 0
      |-> ##62 chip_ready_n ##[1:8] !chip_ready_n) else $error("delay");
   a_sleep_osc: assert property (in_sleep && !avs_write
      |=> osc_run == $past(cfg_q[0])) else $error("osc run");
   a_stable_pair: assert property (osc_stable != chip_ready_n)
      else $error("stable apart");
   cover property (cfg_q[5:4] == 3 && auto_to_idle);
   cover property (!chip_ready_n);
   cover property (in_sleep && osc_run);
endmodule
bind rsc_top rsc_monitor i_rsc_monitor (.*);
`default_nettype wire

// [rsc_radio_model.sv]
// rsc_radio_model.sv: state machine stand-in; cmd 1, 2 or 3 gives one
// start, return or manual calibrate pulse a cycle later.
`timescale 1ns/10ps
`default_nettype none
module rsc_radio_model (
   input wire logic       mclk,
   input wire logic [1:0] cmd,
   output logic           idle_to_active, auto_to_idle, calibrate_strobe
);
   // registered so a pulse never shares its edge with the command
   always @(posedge mclk) idle_to_active <= cmd == 2'h1;
   always @(posedge mclk) auto_to_idle <= cmd == 2'h2;
   always @(posedge mclk) calibrate_strobe <= cmd == 2'h3;
endmodule
`default_nettype wire

// [rsc_top_tb.sv]
// rsc_top_tb.sv: avalon-mm bench for rsc_top.
// assumes rsc_radio_model and the bound rsc_monitor.
`timescale 1ns/10ps
`default_nettype none
module rsc_top_tb;
   logic        mclk = 0, reset = 1, avs_read = 0, avs_write = 0;
   logic        osc_settled = 0, in_sleep = 0;
   logic [1:0]  cmd = 2'h0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
   logic [3:0]  avs_byteenable = 4'hF;
   logic        avs_waitrequest, avs_response_err, synth_cal_start, osc_run;
   logic        chip_ready_n, osc_stable, idle_to_active, auto_to_idle;
   logic        calibrate_strobe, rerr;
   int          errors = 0, checks = 0, cals = 0, n;
   rsc_top i_rsc_top (.*);
   rsc_radio_model i_rsc_radio_model (.*);
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk) if (synth_cal_start === 1'h1) cals <= cals + 1;
   task automatic summarize;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) errors++;
      if (g !== e) $display("unexpected %s exp %h got %h", s, e, g);
   endtask
   // request held until waitrequest is sampled low, one idle edge after
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      int t;
      {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
      for (t = 0; t < 50 && avs_waitrequest !== 1'h0; t++) @(posedge mclk);
      if (t == 50) chk("bus wait", 0, 1);
      if (t == 50) summarize;
      rdat = avs_readdata;
      rerr = avs_response_err;
      {avs_read, avs_write} <= 2'h0;
      @(posedge mclk);
   endtask
   task automatic pulse(logic [1:0] c);
      cmd <= c;
      @(posedge mclk);
      cmd <= 2'h0;
      repeat (3) @(posedge mclk);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 0;
      @(posedge mclk);
      bus(0, 8'h5C, 0);
      chk("cfg reset", 32'h04, rdat);
      chk("cfg err", 0, rerr);
      bus(1, 8'h5C, 32'hFF);
      bus(0, 8'h5C, 0);
      chk("cfg read", 32'h3F, rdat);
      bus(0, 8'h40, 0);
      chk("unmapped", 0, rdat);
      chk("unmapped err", 1, rerr);
      $display("register test done");
      for (int s = 0; s < 4; s++) begin
         bus(1, 8'h5C, s << 4);
         n = cals;
         pulse(2'h1);
         chk("start cal", s == 1, cals - n);
         n = cals;
         repeat (4) pulse(2'h2);
         chk("return cal", s == 2 ? 4 : s == 3, cals - n);
      end
      n = cals;
      pulse(2'h3);
      chk("manual cal", 1, cals - n);
      n = cals;
      bus(1, 8'h64, 1);
      chk("ctrl cal", 1, cals - n);
      $display("calibration test done");
      in_sleep <= 1;
      bus(1, 8'h5C, 0);
      chk("osc sleeps", 0, osc_run);
      bus(1, 8'h5C, 32'h09);
      chk("osc kept", 1, osc_run);
      in_sleep <= 0;
      bus(1, 8'h5C, 0);
      osc_settled <= 1;
      for (n = 0; n < 300 && chip_ready_n !== 1'h0; n++) @(posedge mclk);
      chk("ready delay", 1, n > 63 && n < 70);
      chk("osc stable", 1, osc_stable);
      bus(0, 8'h60, 0);
      chk("status", 32'h2, rdat);
      osc_settled <= 0;
      repeat (3) @(posedge mclk);
      chk("not ready", 1, chip_ready_n);
      $display("ready test done");
      summarize;
   end
endmodule
`default_nettype wire
